// ===== hdl/dgt_diag_telegram.sv
/*
  Diagnosis telegram builder: keeps station status flags and streams the
  29-byte telegram one byte per cycle on a request. Assumes event inputs
  are one-cycle pulses from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dgt_diag_telegram #(
  parameter logic [15:0] MAKER_ID = dgt_pkg::MAKER_ID_DEF
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Status inputs
  input wire logic startup_done,
  input wire dgt_pkg::dgt_evt_t evt,
  input wire logic [dgt_pkg::ID_BITS-1:0] id_entry,
  input wire logic [dgt_pkg::FAULT_BYTES*8-1:0] slave_fault,
  input wire logic [7:0] module_status1,
  input wire logic [7:0] module_status2,
  input wire logic [7:0] module_status3,
  // Diagnosis request and byte stream
  input wire logic diag_req,
  output logic [7:0] tx_byte,
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] master_addr
);
  dgt_pkg::dgt_state_t s;
  dgt_pkg::dgt_state_t next_s;
  logic foreign;
  logic link_fault;
  logic [7:0] tel [0:dgt_pkg::TEL_LEN-1];

  assign link_fault = |slave_fault;
  assign foreign = evt.access && (s.master_addr != {1'b0, evt.access_addr});

  // ------------------------------------------------------------
  // Telegram image
  // ------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < dgt_pkg::TEL_LEN; i++)
    begin
      tel[i] = 8'h00;
    end
    tel[dgt_pkg::HDR_FIRST] = s.st0;
    tel[dgt_pkg::HDR_FIRST + 1] = s.st1;
    tel[dgt_pkg::HDR_FIRST + 2] = dgt_pkg::B2_FIXED;
    tel[dgt_pkg::HDR_FIRST + 3] = s.master_addr;
    tel[dgt_pkg::HDR_FIRST + 4] = MAKER_ID[15:8];
    tel[dgt_pkg::HDR_FIRST + 5] = MAKER_ID[7:0];
    for (int i = 0; i < 3; i++)
    begin
      tel[dgt_pkg::ID_FIRST + i] = s.id_flags[i*8 +: 8];
    end
    tel[dgt_pkg::DEV_FIRST] = dgt_pkg::DEV_LEN;
    tel[dgt_pkg::DEV_FIRST + 1] = 8'h01;
    tel[dgt_pkg::DEV_FIRST + 2] = 8'h04;
    tel[dgt_pkg::DEV_FIRST + 4] = s.mod1;
    tel[dgt_pkg::DEV_FIRST + 5] = 8'h1c;
    tel[dgt_pkg::DEV_FIRST + 6] = s.mod2;
    tel[dgt_pkg::DEV_FIRST + 7] = s.mod3;
    tel[dgt_pkg::DEV_FIRST + 8] = 8'h60;
    tel[dgt_pkg::DEV_FIRST + 10] = 8'h40;
    for (int i = 0; i < dgt_pkg::FAULT_BYTES; i++)
    begin
      tel[dgt_pkg::FAULT_FIRST + i] = s.slave_fault[i*8 +: 8];
    end
  end

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    // Flags are live copies: every change shows in the next telegram
    next_s.id_flags = id_entry;
    next_s.slave_fault = slave_fault;
    next_s.mod1 = module_status1;
    next_s.mod2 = module_status2;
    next_s.mod3 = module_status3;
    next_s.st0[dgt_pkg::B0_UNREACH] = 1'b0;
    next_s.st0[dgt_pkg::B0_BADRESP] = 1'b0;
    next_s.st0[dgt_pkg::B0_NOTREADY] = ~startup_done;
    next_s.st0[dgt_pkg::B0_EXTDIAG] = link_fault;
    next_s.st1[dgt_pkg::B1_STATDIAG] = 1'b0;
    if (evt.prm_ok)
    begin
      next_s.master_addr = {1'b0, evt.prm_addr};
      next_s.st1[dgt_pkg::B1_PRMREQ] = 1'b0;
      next_s.st0[dgt_pkg::B0_PRMERR] = 1'b0;
      next_s.st0[dgt_pkg::B0_CFGERR] = 1'b0;
      next_s.st0[dgt_pkg::B0_UNSUPP] = 1'b0;
    end
    // Error events win over a clear in the same cycle
    if (evt.prm_bad)
    begin
      next_s.st0[dgt_pkg::B0_PRMERR] = 1'b1;
      next_s.st1[dgt_pkg::B1_PRMREQ] = 1'b1;
    end
    if (evt.cfg_bad)
    begin
      next_s.st0[dgt_pkg::B0_CFGERR] = 1'b1;
    end
    if (evt.unsupported)
    begin
      next_s.st0[dgt_pkg::B0_UNSUPP] = 1'b1;
    end
    if (evt.access)
    begin
      next_s.st0[dgt_pkg::B0_FOREIGN] = foreign;
    end
    // Byte stream of the full telegram
    next_s.tx_valid = 1'b0;
    next_s.tx_last = 1'b0;
    if (!s.busy && diag_req)
    begin
      next_s.busy = 1'b1;
      next_s.idx = dgt_pkg::BYTE_IDX_RST;
    end
    else if (s.busy)
    begin
      next_s.tx_byte = tel[s.idx];
      next_s.tx_valid = 1'b1;
      next_s.tx_last = (s.idx == dgt_pkg::LAST_IDX);
      if (s.idx == dgt_pkg::LAST_IDX)
      begin
        next_s.busy = 1'b0;
      end
      next_s.idx = 5'(s.idx + 5'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s <= '0;
      s.st0 <= dgt_pkg::RST_B0;
      s.st1 <= dgt_pkg::RST_B1;
      s.master_addr <= dgt_pkg::NO_MASTER;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign tx_byte = s.tx_byte;
  assign tx_valid = s.tx_valid;
  assign tx_last = s.tx_last;
  assign master_addr = s.master_addr;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence seq_req;
    !s.busy && diag_req;
  endsequence
  sequence seq_stream;
    tx_valid [*8] ##1 tx_valid [*8] ##1 tx_valid [*8] ##1 tx_valid [*5];
  endsequence
  chk_full_telegram: assert property (@(posedge clk) disable iff (!rst_n)
    seq_req |=> !tx_valid ##1 seq_stream ##0 tx_last) else $error("telegram not 29 bytes");
  chk_notready_flag: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (s.st0[1] == !$past(startup_done))) else $error("not-ready bit wrong");
  chk_ext_diag: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (s.st0[3] == $past(|slave_fault))) else $error("ext diag bit wrong");
  chk_cfg_err: assert property (@(posedge clk) disable iff (!rst_n)
    evt.cfg_bad |=> s.st0[2]) else $error("cfg error not set");
  chk_unsupp_flag: assert property (@(posedge clk) disable iff (!rst_n)
    evt.unsupported |=> s.st0[4]) else $error("unsupported not set");
  chk_prm_err: assert property (@(posedge clk) disable iff (!rst_n)
    evt.prm_bad |=> s.st0[6] && s.st1[0]) else $error("param error not set");
  chk_foreign_access: assert property (@(posedge clk) disable iff (!rst_n)
    evt.access && !evt.prm_ok && master_addr != {1'b0, evt.access_addr} |=> s.st0[7])
    else $error("foreign access missed");
  chk_master_range: assert property (@(posedge clk) disable iff (!rst_n)
    master_addr == dgt_pkg::NO_MASTER || master_addr <= {1'b0, dgt_pkg::MAX_MASTER})
    else $error("master address out of range");
  chk_master_load: assert property (@(posedge clk) disable iff (!rst_n)
    evt.prm_ok |=> master_addr == {1'b0, $past(evt.prm_addr)}) else $error("master address not stored");
  chk_master_bits: assert property (@(posedge clk) disable iff (!rst_n)
    !s.st0[0] && !s.st0[5]) else $error("master-owned bit set");
endmodule
`default_nettype wire

// ===== hdl/dgt_pkg.sv
/*
  Constants and carrier types for the slave diagnosis telegram builder.
  Assumes one 50 MHz clock and a synchronous active-low reset.
*/
// Behaviour
// - The telegram is a header in bytes 0-5, identifier part in bytes 6-8 and device part in bytes 9-28.
// - The header holds three station status bytes, the parameterizing master address and the maker identifier.
// - The identifier part flags, per configured transfer-memory address space, whether an entry was made.
// - Every error flag reads one for error and zero for no error.
// - Byte 0 bit 1 is set while start-up is not complete and no cyclic data can flow.
// - Byte 0 bit 2 is set when configuration data from the master is wrong or unsupported.
// - Byte 0 bit 3 is set whenever a link fault exists, so device-related data is present.
// - Byte 0 bit 4 is set when the master requests an unsupported function such as an address change.
// - Byte 0 bit 6 is set on a faulty parameter assignment message.
// - Byte 0 bit 7 is set whenever a master or programming station other than the parameterizing one accesses.
// - The master-address byte reports the address of the parameterizing master.
// - The master-address byte is 0 to 126 for a parameterizing master, or all ones when none.
// - Status byte 1 bit 0 is set when a fresh parameter assignment is required.
// - Per-slave fault bits are set for absent or inactive configured slaves or present unconfigured slaves.
package dgt_pkg;
  // ------------------------------------------------------------
  // Telegram layout
  // ------------------------------------------------------------
  localparam int TEL_LEN = 29;
  localparam int HDR_FIRST = 0;
  localparam int ID_FIRST = 6;
  localparam int DEV_FIRST = 9;
  localparam int DEV_LAST = 28;
  localparam int FAULT_FIRST = 20;
  localparam int FAULT_BYTES = 8;
  localparam int ID_BITS = 24;
  // Byte 0 and byte 1 bit positions
  localparam int B0_UNREACH = 0;
  localparam int B0_NOTREADY = 1;
  localparam int B0_CFGERR = 2;
  localparam int B0_EXTDIAG = 3;
  localparam int B0_UNSUPP = 4;
  localparam int B0_BADRESP = 5;
  localparam int B0_PRMERR = 6;
  localparam int B0_FOREIGN = 7;
  localparam int B1_PRMREQ = 0;
  localparam int B1_STATDIAG = 1;
  // Fixed values and reset values
  localparam logic [7:0] NO_MASTER = 8'hff;
  localparam logic [6:0] MAX_MASTER = 7'h7e;
  localparam logic [7:0] DEV_LEN = 8'h13;
  localparam logic [7:0] B2_FIXED = 8'h00;
  // Arbitrary maker identifier, value chosen freely
  localparam logic [15:0] MAKER_ID_DEF = 16'h1234;
  localparam logic [7:0] RST_B0 = 8'h02;
  localparam logic [7:0] RST_B1 = 8'h01;
  localparam logic [4:0] BYTE_IDX_RST = 5'h00;
  localparam logic [4:0] LAST_IDX = 5'h1c;

  typedef struct packed {
    logic cfg_bad;
    logic unsupported;
    logic prm_bad;
    logic prm_ok;
    logic [6:0] prm_addr;
    logic access;
    logic [6:0] access_addr;
  } dgt_evt_t;

  typedef struct packed {
    logic [7:0] st0;
    logic [7:0] st1;
    logic [7:0] master_addr;
    logic [ID_BITS-1:0] id_flags;
    logic [FAULT_BYTES*8-1:0] slave_fault;
    logic [7:0] mod1;
    logic [7:0] mod2;
    logic [7:0] mod3;
    logic busy;
    logic [4:0] idx;
    logic [7:0] tx_byte;
    logic tx_valid;
    logic tx_last;
  } dgt_state_t;
endpackage

// ===== tb/dgt_diag_telegram_tb.sv
/*
  Self-checking bench for the diagnosis telegram builder.
  Assumes the builder and the master model run from one 50 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dgt_diag_telegram_tb;
  // Arbitrary maker identifier
  localparam logic [15:0] MK = 16'h5a3c;
  logic clk, rst_n, startup_done, diag_req, tx_valid, tx_last, go, done, e1;
  dgt_pkg::dgt_evt_t evt;
  logic [23:0] id_entry;
  logic [63:0] slave_fault;
  logic [7:0] ms1, ms2, ms3, tx_byte, master_addr, e0, ema;
  logic [29*8-1:0] tel;
  int last_at, err_count, tests_run;

  dgt_diag_telegram #(.MAKER_ID(MK)) dut (.clk(clk), .rst_n(rst_n), .startup_done(startup_done), .evt(evt),
    .id_entry(id_entry), .slave_fault(slave_fault), .module_status1(ms1), .module_status2(ms2),
    .module_status3(ms3), .diag_req(diag_req), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last),
    .master_addr(master_addr));
  dgt_master_model master (.clk(clk), .rst_n(rst_n), .go(go), .done(done), .last_at(last_at), .tel(tel),
    .diag_req(diag_req), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_last(tx_last));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [7:0] exp_byte(int i);
    logic [7:0] fx [11];
    fx = '{8'h13, 8'h01, 8'h04, 8'h00, ms1, 8'h1c, ms2, ms3, 8'h60, 8'h00, 8'h40};
    case (i)
      0: return {e0[7:4], |slave_fault, e0[2], ~startup_done, 1'b0};
      1: return {7'h00, e1};
      2: return 8'h00;
      3: return ema;
      4: return MK[15:8];
      5: return MK[7:0];
      6, 7, 8: return id_entry[(i-6)*8 +: 8];
      28: return 8'h00;
      default: return (i < 20) ? fx[i-9] : slave_fault[(i-20)*8 +: 8];
    endcase
  endfunction

  task automatic check8(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d of %0d checks", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One event pulse (none for k=5) plus fresh level inputs
  task automatic step(int k);
    logic [6:0] a;
    a = 7'($urandom_range(0, 126));
    evt = '0;
    case (k)
      0: begin evt.cfg_bad = 1'b1; e0[2] = 1'b1; end
      1: begin evt.unsupported = 1'b1; e0[4] = 1'b1; end
      2: begin evt.prm_bad = 1'b1; e0[6] = 1'b1; e1 = 1'b1; end
      3: begin evt.prm_ok = 1'b1; evt.prm_addr = a; ema = {1'b0, a}; e0 &= 8'hab; e1 = 1'b0; end
      4: begin evt.access = 1'b1; evt.access_addr = $urandom_range(0, 1) ? ema[6:0] : a;
        e0[7] = ({1'b0, evt.access_addr} != ema); end
      default: ;
    endcase
    startup_done = 1'($urandom_range(0, 1));
    id_entry = 24'($urandom);
    slave_fault = $urandom_range(0, 1) ? {$urandom, $urandom} : 64'h0;
    ms1 = 8'($urandom);
    ms2 = 8'($urandom);
    ms3 = 8'($urandom);
    @(negedge clk);
    evt = '0;
  endtask

  task automatic read_tel();
    int w;
    repeat ($urandom_range(0, 3)) @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    w = 0;
    while (done !== 1'b1 && w < 50)
    begin
      @(negedge clk);
      w++;
    end
    if (done !== 1'b1)
    begin
      err_count++;
      stop_test();
    end
    for (int i = 0; i < 29; i++)
    begin
      check8(tel[i*8 +: 8], exp_byte(i));
    end
    check8(8'(last_at), 8'h1c);
    check8(master_addr, ema);
  endtask

  initial
  begin
    void'($urandom(32'hf937));
    {rst_n, go, startup_done, id_entry, slave_fault, ms1, ms2, ms3} = '0;
    evt = '0;
    {e0, e1, ema} = {8'h00, 1'b1, 8'hff};
    err_count = 0;
    tests_run = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    read_tel();
    step(2);
    step(0);
    step(1);
    read_tel();
    step(3);
    step(4);
    read_tel();
    repeat (80)
    begin
      step($urandom_range(0, 5));
      read_tel();
    end
    stop_test();
  end
endmodule
`default_nettype wire

// ===== tb/dgt_master_model.sv
/*
  Bus master model: asks for one telegram per go pulse and collects it.
  Assumes the builder answers on tx_valid and marks the end with tx_last.
*/
`timescale 1ns/1ps
`default_nettype none
module dgt_master_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench side
  input wire logic go,
  output logic done,
  output int last_at,
  output logic [29*8-1:0] tel,
  // Builder side
  output logic diag_req,
  input wire logic [7:0] tx_byte,
  input wire logic tx_valid,
  input wire logic tx_last
);
  logic pend;
  int n;
  initial
  begin
    diag_req = 1'b0;
    pend = 1'b0;
    done = 1'b0;
    n = 0;
    last_at = 0;
    tel = '0;
  end
  // One-cycle request, raised off the sampling edge
  always @(negedge clk) diag_req <= pend & rst_n;
  always @(posedge clk)
  begin
    pend <= go;
    if (go)
    begin
      n <= 0;
      done <= 1'b0;
    end
    else if (tx_valid)
    begin
      tel[n*8 +: 8] <= tx_byte;
      n <= n + 1;
      if (tx_last)
      begin
        done <= 1'b1;
        last_at <= n;
      end
    end
  end
endmodule
`default_nettype wire
